// ==== src/diag_status_pkg.sv ====
// constants for the supply controller diagnostic status bank
package diag_status_pkg;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 8;
  localparam logic [7:0] DIAG_FLAGS_OFFSET = 8'h00;
  localparam logic [7:0] DIAG_SPARE_OFFSET = 8'h01;
  localparam int unsigned OVERLOAD_A_BIT = 0;
  localparam int unsigned OVERLOAD_B_BIT = 1;
  localparam int unsigned OVERTEMP_BIT = 6;
  localparam int unsigned SUPPLY_LOW_BIT = 7;
  localparam logic [7:0] DIAG_FLAGS_RESET = 8'h00;
  localparam logic [7:0] DIAG_SPARE_RESET = 8'h00;
  localparam logic [7:0] VOLT_SEL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam int unsigned VOLT_SEL_WIDTH = 4;
  localparam int unsigned CHANNELS = 2;
endpackage

// ==== src/sync_two_ff.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ==== src/dual_supply_diag_status.sv ====
// diagnostic status bank and protection output control for two supply channels
// Notes on behaviour
// - both status registers are read only; writes to them change nothing
// - first status register sits at address 0x0 and returns its eight bits
// - bit 0 reads 1 while channel A overload protection is triggered
// - bit 1 reads 1 while channel B overload protection is triggered
// - bit 6 reads 1 once junction overtemperature is detected
// - overtemperature flag clears only when the hysteretic detector releases
// - bit 7 reads 1 while the supply input is below low detect threshold
// - second status register at address 0x1 is all reserved
// - all status bits are zero after power-up reset
// - latched overload clears voltage select and disables output; host rewrites
// - without thermal latch, output returns with previous selection when flag clears
`timescale 1ns/1ps
`default_nettype none
module dual_supply_diag_status #(
  parameter int unsigned CHANNELS       = diag_status_pkg::CHANNELS,
  parameter int unsigned VOLT_SEL_WIDTH = diag_status_pkg::VOLT_SEL_WIDTH
) (
  input  wire logic                                   ref_clk,
  input  wire logic                                   arst_n,
  // register access port of the serial interface
  input  wire logic                                   regRead,
  input  wire logic                                   regWrite,
  input  wire logic [diag_status_pkg::ADDR_WIDTH-1:0] regAddr,
  input  wire logic [diag_status_pkg::DATA_WIDTH-1:0] regWdata,
  output var  logic [diag_status_pkg::DATA_WIDTH-1:0] regRdata,
  output var  logic                                   regRvalid,
  // detector levels from the analog side
  input  wire logic [CHANNELS-1:0]                    overloadDetect,
  input  wire logic                                   overtempDetect,
  input  wire logic                                   lowSupplyDetect,
  // control from the data registers
  input  wire logic                                   overloadLatchSelect,
  input  wire logic                                   thermalLatchSelect,
  input  wire logic [CHANNELS*VOLT_SEL_WIDTH-1:0]     outputVoltageSelect,
  input  wire logic                                   voltSelWrite,
  // effective voltage selection and output enables
  output var  logic [CHANNELS*VOLT_SEL_WIDTH-1:0]     voltSelEffective,
  output var  logic [CHANNELS-1:0]                    outputEnable
);
  // all-zero selection means standby; cut once to the selection width
  localparam logic [VOLT_SEL_WIDTH-1:0] VOLT_SEL_RESET_W =
    VOLT_SEL_WIDTH'(diag_status_pkg::VOLT_SEL_RESET);

  logic [CHANNELS-1:0]                    overloadSync;
  logic                                   overtempSync;
  logic                                   lowSupplySync;
  logic [CHANNELS-1:0]                    overloadFlag_reg;
  logic                                   overtempFlag_reg;
  logic                                   supplyLowFlag_reg;
  logic [CHANNELS-1:0]                    overloadPrev_reg;
  logic                                   overtempPrev_reg;
  logic                                   overtempRise;
  logic [diag_status_pkg::DATA_WIDTH-1:0] diagFlags;
  logic [diag_status_pkg::DATA_WIDTH-1:0] regRdata_next;

  sync_two_ff #(.WIDTH(CHANNELS + 2)) detectSync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .asyncIn ({lowSupplyDetect, overtempDetect, overloadDetect}),
    .syncOut ({lowSupplySync, overtempSync, overloadSync})
  );

  // flags follow the synchronised detectors; hysteresis lives in the detector
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overloadFlag_reg <= '0;
    end else begin
      overloadFlag_reg <= overloadSync;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overtempFlag_reg <= 1'b0;
    end else begin
      overtempFlag_reg <= overtempSync;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      supplyLowFlag_reg <= 1'b0;
    end else begin
      supplyLowFlag_reg <= lowSupplySync;
    end
  end

  // previous flag levels, so that a trip is acted upon only at its start
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overtempPrev_reg <= 1'b0;
    end else begin
      overtempPrev_reg <= overtempFlag_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overloadPrev_reg <= '0;
    end else begin
      overloadPrev_reg <= overloadFlag_reg;
    end
  end

  assign overtempRise = overtempFlag_reg & ~overtempPrev_reg;

  always_comb begin
    diagFlags = diag_status_pkg::DIAG_FLAGS_RESET;
    diagFlags[diag_status_pkg::OVERLOAD_A_BIT] = overloadFlag_reg[0];
    diagFlags[diag_status_pkg::OVERLOAD_B_BIT] = overloadFlag_reg[CHANNELS-1];
    diagFlags[diag_status_pkg::OVERTEMP_BIT]   = overtempFlag_reg;
    diagFlags[diag_status_pkg::SUPPLY_LOW_BIT] = supplyLowFlag_reg;
  end

  // read decode; unmapped addresses answer zero rather than alias a register
  always_comb begin
    case (regAddr)
      diag_status_pkg::DIAG_FLAGS_OFFSET: begin
        regRdata_next = diagFlags;
      end
      diag_status_pkg::DIAG_SPARE_OFFSET: begin
        regRdata_next = diag_status_pkg::DIAG_SPARE_RESET;
      end
      default: begin
        regRdata_next = diag_status_pkg::UNMAPPED_RDATA;
      end
    endcase
  end

  // regWrite and regWdata reach no storage, so writes change nothing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= diag_status_pkg::DIAG_FLAGS_RESET;
    end else if (regRead) begin
      regRdata <= regRdata_next;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
    end
  end

  // per channel output control under protection events
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : chanCtl
      logic [VOLT_SEL_WIDTH-1:0] voltSel_reg;
      logic                      olLatched_reg;
      logic                      otLatched_reg;
      logic                      overloadRise;
      logic                      overloadTrip;
      logic                      thermalTrip;
      logic                      outputEnable_next;

      assign overloadRise = overloadFlag_reg[ch] & ~overloadPrev_reg[ch];
      assign overloadTrip = overloadRise & overloadLatchSelect;
      assign thermalTrip  = overtempRise & thermalLatchSelect;

      // a new trip wins over a rewrite that lands in the same cycle
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          olLatched_reg <= 1'b0;
        end else begin
          if (overloadTrip) begin
            olLatched_reg <= 1'b1;
          end else if (voltSelWrite && !overloadFlag_reg[ch]) begin
            olLatched_reg <= 1'b0;
          end
        end
      end

      // thermal latch needs a rewrite after the flag clears, like the overload latch
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          otLatched_reg <= 1'b0;
        end else begin
          if (thermalTrip) begin
            otLatched_reg <= 1'b1;
          end else if (voltSelWrite && !overtempFlag_reg) begin
            otLatched_reg <= 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          voltSel_reg <= VOLT_SEL_RESET_W;
        end else if (overloadTrip || thermalTrip) begin
          voltSel_reg <= VOLT_SEL_RESET_W;
        end else if (voltSelWrite) begin
          voltSel_reg <= outputVoltageSelect[ch*VOLT_SEL_WIDTH +: VOLT_SEL_WIDTH];
        end
      end

      // unlatched thermal trip resumes with the held selection
      assign outputEnable_next = !olLatched_reg && !otLatched_reg && !overtempFlag_reg
                                 && !(overloadFlag_reg[ch] && overloadLatchSelect)
                                 && (voltSel_reg != VOLT_SEL_RESET_W);

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          outputEnable[ch] <= 1'b0;
        end else begin
          outputEnable[ch] <= outputEnable_next;
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          voltSelEffective[ch*VOLT_SEL_WIDTH +: VOLT_SEL_WIDTH] <= VOLT_SEL_RESET_W;
        end else begin
          voltSelEffective[ch*VOLT_SEL_WIDTH +: VOLT_SEL_WIDTH] <= voltSel_reg;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verif/dual_supply_diag_status_chk.sv ====
// port-level checks of the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
module dual_supply_diag_status_chk (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       regRead,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic       regRvalid,
  input wire logic [1:0] overloadDetect,
  input wire logic       overtempDetect,
  input wire logic       lowSupplyDetect
);
  logic       [2:0] upCnt;
  wire  logic [3:0] det = {lowSupplyDetect, overtempDetect, overloadDetect};
  // flags need a few edges after reset before they follow the detectors
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) upCnt <= 3'h0;
    else if (!upCnt[2]) upCnt <= upCnt + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence quiet_rd(a);
    (upCnt[2] && $stable(det)) [*4] ##0 (regRead && regAddr == a);
  endsequence
  read_answer_a: assert property (regRead |=> regRvalid) else $error("no answer");
  stray_answer_a: assert property (!regRead |=> !regRvalid) else $error("stray answer");
  data_hold_a: assert property (!regRvalid |-> $stable(regRdata)) else $error("data moved");
  chan_a_a: assert property (quiet_rd(8'h00) |=> regRdata[0] == $past(det[0]))
    else $error("channel a flag");
  chan_b_a: assert property (quiet_rd(8'h00) |=> regRdata[1] == $past(det[1]))
    else $error("channel b flag");
  overtemp_flag_a: assert property (quiet_rd(8'h00) |=> regRdata[6] == $past(det[2]))
    else $error("overtemp flag");
  supply_flag_a: assert property (quiet_rd(8'h00) |=> regRdata[7] == $past(det[3]))
    else $error("supply flag");
  reserved_zero_a: assert property (regRead && regAddr == 8'h00 |=> regRdata[5:2] == 4'h0)
    else $error("reserved bits set");
  spare_zero_a: assert property (regRead && regAddr != 8'h00 |=> regRdata == 8'h00)
    else $error("spare not zero");
  cover property (regRead && regAddr == 8'h00 ##1 regRdata != 8'h00);
  cover property (regRead && regAddr == 8'h01);
  cover property (regWrite);
endmodule
bind dual_supply_diag_status dual_supply_diag_status_chk CHKR (.ref_clk, .arst_n, .regRead,
  .regWrite, .regAddr, .regRdata, .regRvalid, .overloadDetect, .overtempDetect, .lowSupplyDetect);
`default_nettype wire

// ==== verif/host_model.sv ====
// host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       ref_clk,
  output var  logic       regRead,
  output var  logic       regWrite,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWdata,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid
);
  initial {regRead, regWrite, regAddr, regWdata} = '0;
  // one-edge strobe, address kept until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (regRvalid !== 1'b1 && n < 8);
    d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
    regAddr <= ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~v;
  endtask
endmodule
`default_nettype wire

// ==== verif/dual_supply_diag_status_bench.sv ====
// self-checking bench for the diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module dual_supply_diag_status_bench;
  logic            ref_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic      [3:0] det = 4'h0;
  logic            olSel = 1'b0;
  logic            thSel = 1'b0;
  logic            voltSelWr = 1'b0;
  logic      [7:0] voltSel = 8'h00;
  logic      [7:0] d;
  wire logic       regRead, regWrite, regRvalid;
  wire logic [7:0] regAddr, regWdata, regRdata, voltSelEff;
  wire logic [1:0] outEn;
  int              error_cnt = 0;
  int              checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  host_model HOST (.ref_clk, .regRead, .regWrite, .regAddr, .regWdata, .regRdata, .regRvalid);
  dual_supply_diag_status DUT (.ref_clk, .arst_n, .regRead, .regWrite, .regAddr, .regWdata,
    .regRdata, .regRvalid, .overloadDetect(det[1:0]), .overtempDetect(det[2]),
    .lowSupplyDetect(det[3]), .overloadLatchSelect(olSel), .thermalLatchSelect(thSel),
    .outputVoltageSelect(voltSel), .voltSelWrite(voltSelWr), .voltSelEffective(voltSelEff),
    .outputEnable(outEn));
  task automatic set_det(input logic [3:0] v);
    @(posedge ref_clk);
    det <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic rewrite_sel;
    @(posedge ref_clk);
    voltSelWr <= 1'b1;
    @(posedge ref_clk);
    voltSelWr <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic final_report;
    $display("compares %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    HOST.rd(8'h00, d);
    `CHK(d, 8'h00)
    HOST.rd(8'h01, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 16; i++) begin
      set_det(i[3:0]);
      HOST.rd(8'h00, d);
      `CHK(d, {i[3], i[2], 4'h0, i[1:0]})
      HOST.wr({7'h00, i[0]}, 8'hff);
      HOST.rd(8'h01, d);
      `CHK(d, 8'h00)
    end
    HOST.rd(8'h7e, d);
    `CHK(d, 8'h00)
    $display("test flags done");
    voltSel <= 8'h21;
    rewrite_sel();
    set_det(4'h4);
    `CHK({voltSelEff, outEn}, {8'h21, 2'h0})
    set_det(4'h0);
    `CHK({voltSelEff, outEn}, {8'h21, 2'h3})
    olSel <= 1'b1;
    set_det(4'h1);
    set_det(4'h0);
    `CHK({voltSelEff, outEn}, {8'h20, 2'h2})
    rewrite_sel();
    `CHK({voltSelEff, outEn}, {8'h21, 2'h3})
    thSel <= 1'b1;
    set_det(4'h4);
    set_det(4'h0);
    `CHK({voltSelEff, outEn}, {8'h00, 2'h0})
    rewrite_sel();
    `CHK({voltSelEff, outEn}, {8'h21, 2'h3})
    $display("test protection done");
    final_report();
  end
endmodule
`default_nettype wire
